// file: verilog/failsafe_error_monitor.sv
// Failsafe error monitor: collects fault detections, forms the error
// code, drives diagnostic mode and the serial output word.
// Assumes fault inputs come from logic on hclk; AHB-Lite single slave.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "failsafe_regs.svh"

// Overview of operation
// - Concurrent C0xx codes combine by bitwise OR
// - Watchdog timeout overwrites pending signature/config code
// - Watchdog: start 69632 clocks, plus ROM check time when enabled; cycle twice
// - RAM parity error gives C001 at once
// - Config register parity error gives C002 at once
// - EEPROM multi-bit error at start-up gives C004
// - EEPROM signature mismatch during readout gives C0AA
// - Enabled ROM signature failure gives C0CC
// - Older revisions: inconsistent configuration gives C0FF
// - Arithmetic self-check failure gives C010
// - Enabled sensor connection failure: temporary C010
// - Temperature at zero or full scale: temporary
// - Enabled sensor short checks, both biases: temporary
// - Common-mode limit violation, skipped at FF00
// - Oscillator fault within 200us, temporary, no code
// - Temporary mode: two fails enter, count-down leaves
// - Diagnostic mode loads code, forces serial interfaces
// - 16/15-bit temperature shifted to 14/13 bits
// - Output word MSB flags an error code
module failsafe_error_monitor
    import failsafe_pkg::*;
#(
    parameter int OSC_DETECT_CYCLES = `OSC_DETECT_TIME_NS / `CLK_PERIOD_NS,
    parameter int START_LIMIT_CYCLES = `START_ROUTINE_CLOCKS,
    parameter int ROM_CHECK_CYCLES = `ROM_CHECK_TIME_NS / `CLK_PERIOD_NS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic command_mode,
    input wire logic undefined_command,
    input wire logic inconsistent_config,
    input wire logic start_phase_done,
    input wire logic cycle_done,
    input wire logic ram_parity_error,
    input wire logic config_reg_parity_error,
    input wire logic eeprom_readout_active,
    input wire logic eeprom_multibit_error,
    input wire logic eeprom_signature_error,
    input wire logic rom_signature_fail,
    input wire logic arithmetic_fail,
    input wire logic oscillator_fail,
    input wire logic check_strobe,
    input wire logic sensor_connection_fail,
    input wire logic sensor_short_pos_fail,
    input wire logic sensor_short_neg_fail,
    input wire logic [15:0] temperature_raw,
    input wire logic [1:0] temperature_resolution,
    input wire logic [15:0] common_mode_value,
    input wire logic [14:0] measurement_result,
    output logic [15:0] serial_output_word,
    output logic serial_force_enable,
    output logic diagnostic_active,
    output logic reset_request,
    output logic reload_from_eeprom
);

    localparam int OSC_SAMPLE_CYCLES = OSC_DETECT_CYCLES / 2;

    // Resolution code 0..3 stands for 13..16 bits
    function automatic logic temp_out_of_range(input logic [15:0] raw,
                                               input logic [1:0] res);
        logic [15:0] value;
        logic [15:0] full;
        value = res[1] ? (raw >> 2) : raw;
        full = res[0] ? `TEMP_FULL_14 : `TEMP_FULL_13;
        value = value & full;
        return (value == 16'h0000) || (value >= full);
    endfunction

    logic [7:0] addr_q;
    logic write_q;
    logic [3:0] config_bits;
    logic [15:0] cmv_limit_a;
    logic [15:0] cmv_limit_b;
    logic [15:0] cycle_time;
    code_t latched_code;
    code_t error_code;
    code_t next_error_code;
    code_t set_code;
    logic latched_dm;
    logic temp_active;
    logic osc_active;
    logic [31:0] osc_timer;
    logic osc_eval;
    logic sensor_fail;
    logic cmv_fail;
    logic ev_ram;
    logic ev_reg;
    logic ev_emc;
    logic ev_ecs;
    logic ev_rsc;
    logic ev_icc;
    logic ev_acc;
    logic ev_wdg;
    logic resettable;
    logic latching;
    logic reload_cmd;
    logic go_reset;
    mode_t mode;

    watchdog_if wd ();

    // Zero-wait slave; every transfer answers OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_q <= 8'h00;
            write_q <= 1'b0;
        end
        else if (hready)
        begin
            addr_q <= haddr[7:0];
            write_q <= hsel && htrans[1] && hwrite && hsize == 3'b010;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            config_bits <= `RST_CONFIG;
            cmv_limit_a <= `RST_CMV_LIMIT_A;
            cmv_limit_b <= `RST_CMV_LIMIT_B;
            cycle_time <= `RST_CYCLE_TIME;
        end
        else if (write_q)
        begin
            case (addr_q)
                `OFS_CONFIG: config_bits <= hwdata[3:0];
                `OFS_CMV_LIMIT_A: cmv_limit_a <= hwdata[15:0];
                `OFS_CMV_LIMIT_B: cmv_limit_b <= hwdata[15:0];
                `OFS_CYCLE_TIME: cycle_time <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    assign reload_cmd = write_q && addr_q == `OFS_COMMAND
                        && hwdata[`CMD_RELOAD_FROM_EEPROM];

    // Read data sampled in the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                `OFS_CONFIG: hrdata <= {28'h0000000, config_bits};
                `OFS_CMV_LIMIT_A: hrdata <= {16'h0000, cmv_limit_a};
                `OFS_CMV_LIMIT_B: hrdata <= {16'h0000, cmv_limit_b};
                `OFS_CYCLE_TIME: hrdata <= {16'h0000, cycle_time};
                `OFS_ERROR_CODE: hrdata <= {16'h0000, error_code};
                `OFS_STATUS: hrdata <= {26'h0, mode, osc_active,
                                        temp_active, latched_dm, diagnostic_active};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Watchdog: ROM check lengthens the start routine when enabled
    assign wd.restart = reload_cmd;
    assign wd.start_phase_done = start_phase_done;
    assign wd.cycle_done = cycle_done;
    assign wd.pause = command_mode;
    assign wd.start_limit = START_LIMIT_CYCLES[31:0]
        + (config_bits[`CFG_ROM_CHECK_ENABLE] ? ROM_CHECK_CYCLES[31:0] : 32'd0);
    assign wd.cycle_limit = {cycle_time, 1'b0};

    watchdog_timer u_watchdog (
        .hclk(hclk),
        .hresetn(hresetn),
        .wd(wd)
    );

    // Latching fault events
    assign ev_wdg = wd.timeout;
    assign ev_ram = ram_parity_error;
    assign ev_reg = config_reg_parity_error;
    assign ev_emc = eeprom_multibit_error && eeprom_readout_active;
    assign ev_ecs = eeprom_signature_error && eeprom_readout_active;
    assign ev_rsc = rom_signature_fail && config_bits[`CFG_ROM_CHECK_ENABLE];
    assign ev_icc = config_bits[`CFG_LEGACY_CONFIG_CHECK]
                    && (inconsistent_config || (undefined_command && command_mode));
    assign ev_acc = arithmetic_fail;

    always_comb
    begin
        set_code = 16'h0000;
        if (ev_ram)
            set_code = set_code | `ERR_RAM_PARITY;
        if (ev_reg)
            set_code = set_code | `ERR_REG_PARITY;
        if (ev_emc)
            set_code = set_code | `ERR_EEPROM_MULTIBIT;
        if (ev_ecs)
            set_code = set_code | `ERR_EEPROM_SIGNATURE;
        if (ev_rsc)
            set_code = set_code | `ERR_ROM_SIGNATURE;
        if (ev_icc)
            set_code = set_code | `ERR_INCONSISTENT;
        if (ev_acc)
            set_code = set_code | `ERR_SENSOR;
    end

    assign resettable = ev_wdg || ev_ram || ev_reg || ev_acc;
    assign go_reset = resettable && config_bits[`CFG_RESET_ON_FAULT];
    assign latching = (resettable && !config_bits[`CFG_RESET_ON_FAULT])
                      || ev_emc || ev_ecs || ev_rsc || ev_icc;

    // Codes accumulate; a watchdog expiry replaces whatever was pending.
    // A fault in the reload cycle survives the clear.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            latched_code <= 16'h0000;
        else if (ev_wdg)
            latched_code <= `ERR_WATCHDOG;
        else
            latched_code <= (reload_cmd ? 16'h0000 : latched_code) | set_code;
    end

    // No self-recovery: only reset or reload leaves this
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            latched_dm <= 1'b0;
        else if (latching)
            latched_dm <= 1'b1;
        else if (reload_cmd)
            latched_dm <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reset_request <= 1'b0;
            reload_from_eeprom <= 1'b0;
        end
        else
        begin
            reset_request <= go_reset;
            reload_from_eeprom <= reload_cmd;
        end
    end

    // Temporary checks, evaluated once per measurement cycle
    assign cmv_fail = cmv_limit_a != `CMV_CHECK_OFF
                      && (common_mode_value < cmv_limit_a
                          || common_mode_value > cmv_limit_b);
    assign sensor_fail = (config_bits[`CFG_SENSOR_CHECK_ENABLE]
                          && (sensor_connection_fail
                              || sensor_short_pos_fail || sensor_short_neg_fail))
                         || temp_out_of_range(temperature_raw, temperature_resolution)
                         || cmv_fail;

    fault_counter u_sensor_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .eval(check_strobe),
        .fail(sensor_fail),
        .active(temp_active)
    );

    // Two samples per detection window keep two-in-a-row inside 200us
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_timer <= 32'd0;
            osc_eval <= 1'b0;
        end
        else if (osc_timer + 32'd1 >= OSC_SAMPLE_CYCLES[31:0])
        begin
            osc_timer <= 32'd0;
            osc_eval <= 1'b1;
        end
        else
        begin
            osc_timer <= osc_timer + 32'd1;
            osc_eval <= 1'b0;
        end
    end

    fault_counter u_osc_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .eval(osc_eval),
        .fail(oscillator_fail),
        .active(osc_active)
    );

    // Oscillator fault adds no code
    assign next_error_code = latched_code | (temp_active ? `ERR_SENSOR : 16'h0000);

    always_comb
    begin
        if (latched_dm || temp_active || osc_active)
            mode = diagnostic_fault_state;
        else if (command_mode)
            mode = calibration_command_state;
        else
            mode = normal_run_state;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            error_code <= 16'h0000;
            diagnostic_active <= 1'b0;
            serial_force_enable <= 1'b0;
        end
        else
        begin
            error_code <= next_error_code;
            diagnostic_active <= mode == diagnostic_fault_state;
            serial_force_enable <= mode == diagnostic_fault_state;
        end
    end

    // Error codes carry MSB set, measurements never do
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            serial_output_word <= 16'h0000;
        else if (mode == diagnostic_fault_state)
            serial_output_word <= next_error_code;
        else
            serial_output_word <= {1'b0, measurement_result};
    end
endmodule

`default_nettype wire

// file: pkg/failsafe_regs.svh
// Register offsets, field positions, reset values and timing counts
// of the failsafe error monitor. Definitions only.
`ifndef FAILSAFE_REGS_SVH
`define FAILSAFE_REGS_SVH

`define OFS_CONFIG 8'h00
`define OFS_CMV_LIMIT_A 8'h04
`define OFS_CMV_LIMIT_B 8'h08
`define OFS_CYCLE_TIME 8'h0C
`define OFS_ERROR_CODE 8'h10
`define OFS_STATUS 8'h14
`define OFS_COMMAND 8'h18

`define CFG_ROM_CHECK_ENABLE 0
`define CFG_SENSOR_CHECK_ENABLE 1
`define CFG_LEGACY_CONFIG_CHECK 2
`define CFG_RESET_ON_FAULT 3
`define CMD_RELOAD_FROM_EEPROM 0

`define ST_DIAG 0
`define ST_LATCHED 1
`define ST_TEMPORARY 2
`define ST_OSC 3
`define ST_MODE_LO 4

`define RST_CONFIG 4'h3
`define RST_CMV_LIMIT_A 16'hFF00
`define RST_CMV_LIMIT_B 16'hFFFF
`define RST_CYCLE_TIME 16'h1000

`define CMV_CHECK_OFF 16'hFF00
`define TEMP_FULL_14 16'h3FFF
`define TEMP_FULL_13 16'h1FFF

`define ERR_RAM_PARITY 16'hC001
`define ERR_REG_PARITY 16'hC002
`define ERR_EEPROM_MULTIBIT 16'hC004
`define ERR_WATCHDOG 16'hC008
`define ERR_SENSOR 16'hC010
`define ERR_EEPROM_SIGNATURE 16'hC0AA
`define ERR_ROM_SIGNATURE 16'hC0CC
`define ERR_INCONSISTENT 16'hC0FF

`define CLK_PERIOD_NS 10
`define OSC_DETECT_TIME_NS 200000
`define ROM_CHECK_TIME_NS 10000000
`define START_ROUTINE_CLOCKS 69632
`define FAIL_COUNT_ENTER 2'd2

`endif

// file: pkg/failsafe_pkg.sv
// Types shared by the failsafe error monitor and its helpers.
// Assumes the constants of failsafe_regs.svh alongside.
package failsafe_pkg;

    typedef enum logic [1:0] {
        normal_run_state,
        calibration_command_state,
        diagnostic_fault_state
    } mode_t;

    typedef logic [15:0] code_t;

endpackage

// file: pkg/watchdog_if.sv
// Signals between the monitor and its watchdog timer.
// Assumes both ends on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface watchdog_if;
    logic restart;
    logic start_phase_done;
    logic cycle_done;
    logic pause;
    logic [31:0] start_limit;
    logic [16:0] cycle_limit;
    logic timeout;

    modport monitor (
        output restart,
        output start_phase_done,
        output cycle_done,
        output pause,
        output start_limit,
        output cycle_limit,
        input timeout
    );

    modport timer (
        input restart,
        input start_phase_done,
        input cycle_done,
        input pause,
        input start_limit,
        input cycle_limit,
        output timeout
    );
endinterface

`default_nettype wire

// file: verilog/fault_counter.sv
// Up/down failure counter for temporary diagnostic handling.
// Assumes eval pulses once per check, with fail valid alongside.
`timescale 1ns/10ps
`default_nettype none

module fault_counter
    import failsafe_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic eval,
    input wire logic fail,
    output logic active
);
    `include "failsafe_regs.svh"

    logic [1:0] count;

    // Saturating count: up on fail, down on pass
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count <= 2'd0;
        else if (eval && fail && count != `FAIL_COUNT_ENTER)
            count <= count + 2'd1;
        else if (eval && !fail && count != 2'd0)
            count <= count - 2'd1;
    end

    // Enter on two consecutive fails, leave once counted down to zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            active <= 1'b0;
        else if (eval && fail && count == `FAIL_COUNT_ENTER - 2'd1)
            active <= 1'b1;
        else if (eval && !fail && count <= 2'd1)
            active <= 1'b0;
    end
endmodule

`default_nettype wire

// file: verilog/watchdog_timer.sv
// Watchdog for the start routine and the measurement cycle.
// Assumes limits stable while counting; timeout is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none

module watchdog_timer
    import failsafe_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    watchdog_if.timer wd
);
    logic [31:0] count;
    logic in_start;
    logic expired;
    logic [31:0] limit;

    assign limit = in_start ? wd.start_limit : {15'd0, wd.cycle_limit};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            in_start <= 1'b1;
        else if (wd.restart)
            in_start <= 1'b1;
        else if (wd.start_phase_done)
            in_start <= 1'b0;
    end

    // One report per expiry; a new kick rearms it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= 32'd0;
            expired <= 1'b0;
            wd.timeout <= 1'b0;
        end
        else
        begin
            wd.timeout <= 1'b0;
            if (wd.restart || wd.start_phase_done || (wd.cycle_done && !in_start))
            begin
                count <= 32'd0;
                expired <= 1'b0;
            end
            else if (!wd.pause && !expired)
            begin
                if (count >= limit)
                begin
                    expired <= 1'b1;
                    wd.timeout <= 1'b1;
                end
                else
                    count <= count + 32'd1;
            end
        end
    end
endmodule

`default_nettype wire

// file: dv/failsafe_error_monitor_assertions.sv
// Port-level checks on the failsafe error monitor.
// Assumes fault pulses come from logic on hclk; bound to the monitor.
`timescale 1ns/10ps
`default_nettype none

module failsafe_checker
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ram_parity_error,
    input wire logic config_reg_parity_error,
    input wire logic arithmetic_fail,
    input wire logic eeprom_readout_active,
    input wire logic eeprom_multibit_error,
    input wire logic eeprom_signature_error,
    input wire logic [14:0] measurement_result,
    input wire logic [15:0] serial_output_word,
    input wire logic serial_force_enable,
    input wire logic diagnostic_active,
    input wire logic reset_request,
    input wire logic reload_from_eeprom
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Set when diagnostic mode is on the cycle after a RAM parity error; only reset or a reload may end it
    logic latch_seen;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            latch_seen <= 1'b0;
        else if (reload_from_eeprom)
            latch_seen <= 1'b0;
        else if (diagnostic_active && $past(ram_parity_error))
            latch_seen <= 1'b1;
    end

    property p_ram_parity;
        ram_parity_error |-> ##2 (diagnostic_active || $past(reset_request));
    endproperty
    a_ram_parity: assert property (p_ram_parity)
        else $error("RAM parity not handled");
    property p_reg_parity;
        config_reg_parity_error |-> ##2 (diagnostic_active || $past(reset_request));
    endproperty
    a_reg_parity: assert property (p_reg_parity)
        else $error("Register parity not handled");
    property p_multibit;
        eeprom_readout_active && eeprom_multibit_error
            |-> ##2 diagnostic_active && serial_output_word[2];
    endproperty
    a_multibit: assert property (p_multibit)
        else $error("EEPROM multi-bit fault not reported");
    property p_signature;
        eeprom_readout_active && eeprom_signature_error
            |-> ##2 diagnostic_active && ((serial_output_word & 16'h00AA) == 16'h00AA);
    endproperty
    a_signature: assert property (p_signature)
        else $error("EEPROM signature fault not reported");
    property p_arith;
        arithmetic_fail |-> ##2 (diagnostic_active || $past(reset_request));
    endproperty
    a_arith: assert property (p_arith)
        else $error("Arithmetic fault not handled");
    property p_force;
        serial_force_enable == diagnostic_active;
    endproperty
    a_force: assert property (p_force)
        else $error("Serial enable not diagnostic");
    property p_normal_word;
        $past(hresetn) && !diagnostic_active
            |-> serial_output_word == {1'b0, $past(measurement_result)};
    endproperty
    a_normal_word: assert property (p_normal_word)
        else $error("Output word not measurement");
    property p_latched;
        latch_seen && !reload_from_eeprom |-> diagnostic_active;
    endproperty
    a_latched: assert property (p_latched)
        else $error("Latched mode left early");
endmodule

bind failsafe_error_monitor failsafe_checker failsafe_checker_i (.*);

`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the failsafe error monitor.
// Assumes one AHB-Lite slave; all fault sources driven by the bench.
`timescale 1ns/10ps
`default_nettype none
`include "failsafe_regs.svh"

module tb_top;
    import failsafe_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, serial_force_enable, diagnostic_active;
    logic reset_request, reload_from_eeprom, cycle_done = 1'b0, kick_on = 1'b0, rr;
    logic command_mode = 1'b0, eeprom_readout_active = 1'b0, oscillator_fail = 1'b0;
    logic check_strobe = 1'b0, sensor_connection_fail = 1'b0;
    logic sensor_short_pos_fail = 1'b0, sensor_short_neg_fail = 1'b0;
    logic [15:0] temperature_raw = 16'h0, common_mode_value = 16'h0, serial_output_word;
    logic [1:0] temperature_resolution = 2'h3;
    logic [14:0] measurement_result = 15'h1234;
    logic [8:0] ev = 9'h0;
    logic [5:0] kcnt = 6'h0;
    logic [7:0] addr_tab [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    logic [31:0] exp_tab [7] = '{32'h3, 32'hFF00, 32'hFFFF, 32'h1000, 32'h0, 32'h0, 32'h0};
    int n_mismatch = 0;
    int n_checks = 0;

    assign hready = hreadyout;
    always #5 hclk = ~hclk;

    failsafe_error_monitor #(.OSC_DETECT_CYCLES(8), .START_LIMIT_CYCLES(50),
        .ROM_CHECK_CYCLES(20)) failsafe_error_monitor_i (
        .*, .undefined_command(ev[6]), .inconsistent_config(ev[7]), .start_phase_done(ev[8]),
        .ram_parity_error(ev[0]), .config_reg_parity_error(ev[1]), .eeprom_multibit_error(ev[2]),
        .eeprom_signature_error(ev[3]), .rom_signature_fail(ev[4]), .arithmetic_fail(ev[5]));

    // Kick every 64 cycles, well inside twice the cycle time
    always @(posedge hclk)
    begin
        kcnt <= kcnt + 6'h1;
        cycle_done <= kick_on && (kcnt == 6'h0);
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkd(input logic e);
        chk({31'h0, diagnostic_active}, {31'h0, e});
    endtask

    task automatic chkw(input logic [15:0] e);
        chk({16'h0, serial_output_word}, {16'h0, e});
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rv = hrdata;
    endtask

    task automatic pulse(input logic [8:0] m);
        @(posedge hclk);
        ev <= m;
        @(posedge hclk);
        ev <= 9'h0;
        #1 rr = reset_request;
        @(posedge hclk);
        #1;
    endtask

    task automatic reload;
        bus(1'b1, `OFS_COMMAND, 32'h1);
        pulse(9'h100);
    endtask

    task automatic reset_dut(input logic start);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        if (start)
            pulse(9'h100);
    endtask

    task automatic wait_diag(input logic e, input int n);
        for (int i = 0; i < n && diagnostic_active !== e; i++)
            @(posedge hclk);
        #1;
    endtask

    // 0 passes; 1..6 fail one sensor-group check each
    task automatic strobe(input int k);
        @(posedge hclk);
        sensor_connection_fail <= (k == 1);
        sensor_short_pos_fail <= (k == 2);
        sensor_short_neg_fail <= (k == 3);
        temperature_raw <= (k == 4) ? 16'h0000 : (k == 5) ? 16'hFFFC : 16'hFFF8;
        common_mode_value <= (k == 6) ? 16'h0050 : 16'h0150;
        check_strobe <= 1'b1;
        @(posedge hclk);
        check_strobe <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
    endtask

    initial
    begin
        #500000;
        n_mismatch++;
        test_done;
    end

    initial
    begin
        reset_dut(1'b1);
        kick_on <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, addr_tab[i], 32'h0);
            chk(rv, exp_tab[i]);
        end
        bus(1'b1, `OFS_ERROR_CODE, 32'h5555);
        bus(1'b0, `OFS_ERROR_CODE, 32'h0);
        chk(rv, 32'h0);
        chkw({1'b0, measurement_result});
        $display("test reset_values done");
        pulse(9'h001);
        chkd(1'b1);
        chk({31'h0, serial_force_enable}, 32'h1);
        chkw(`ERR_RAM_PARITY);
        repeat (20) @(posedge hclk);
        chkd(1'b1);
        pulse(9'h002);
        chkw(`ERR_RAM_PARITY | `ERR_REG_PARITY);
        bus(1'b0, `OFS_ERROR_CODE, 32'h0);
        chk(rv, {16'h0, `ERR_RAM_PARITY | `ERR_REG_PARITY});
        reload;
        chkd(1'b0);
        $display("test latched done");
        pulse(9'h004);
        chkd(1'b0);
        eeprom_readout_active <= 1'b1;
        pulse(9'h00C);
        eeprom_readout_active <= 1'b0;
        chkw(`ERR_EEPROM_MULTIBIT | `ERR_EEPROM_SIGNATURE);
        reload;
        bus(1'b1, `OFS_CONFIG, 32'h2);
        pulse(9'h010);
        chkd(1'b0);
        bus(1'b1, `OFS_CONFIG, 32'h3);
        pulse(9'h010);
        chkw(`ERR_ROM_SIGNATURE);
        reload;
        bus(1'b1, `OFS_CONFIG, 32'h2);
        pulse(9'h080);
        chkd(1'b0);
        bus(1'b1, `OFS_CONFIG, 32'h6);
        command_mode <= 1'b1;
        pulse(9'h040);
        command_mode <= 1'b0;
        chkw(`ERR_INCONSISTENT);
        reload;
        bus(1'b1, `OFS_CONFIG, 32'hB);
        pulse(9'h020);
        chk({31'h0, rr}, 32'h1);
        chkd(1'b0);
        bus(1'b0, `OFS_ERROR_CODE, 32'h0);
        chk(rv, {16'h0, `ERR_SENSOR});
        reset_dut(1'b1);
        $display("test latched_codes done");
        bus(1'b1, `OFS_CMV_LIMIT_A, 32'h100);
        bus(1'b1, `OFS_CMV_LIMIT_B, 32'h200);
        for (int k = 1; k < 7; k++)
        begin
            strobe(k);
            strobe(0);
            strobe(k);
            chkd(1'b0);
            strobe(k);
            chkd(1'b1);
            chkw(`ERR_SENSOR);
            strobe(0);
            chkd(1'b1);
            strobe(0);
            chkd(1'b0);
        end
        bus(1'b1, `OFS_CMV_LIMIT_A, {16'h0, `CMV_CHECK_OFF});
        strobe(6);
        strobe(6);
        chkd(1'b0);
        bus(1'b1, `OFS_CONFIG, 32'h1);
        strobe(1);
        strobe(1);
        chkd(1'b0);
        bus(1'b1, `OFS_CONFIG, 32'h3);
        oscillator_fail <= 1'b1;
        wait_diag(1'b1, 20);
        chkd(1'b1);
        oscillator_fail <= 1'b0;
        wait_diag(1'b0, 40);
        chkd(1'b0);
        $display("test temporary done");
        eeprom_readout_active <= 1'b1;
        pulse(9'h008);
        eeprom_readout_active <= 1'b0;
        bus(1'b1, `OFS_CYCLE_TIME, 32'h40);
        repeat (70) @(posedge hclk);
        kick_on <= 1'b0;
        repeat (50) @(posedge hclk);
        chkw(`ERR_EEPROM_SIGNATURE);
        for (int i = 0; i < 100 && serial_output_word !== `ERR_WATCHDOG; i++)
            @(posedge hclk);
        #1;
        chkw(`ERR_WATCHDOG);
        reset_dut(1'b0);
        repeat (60) @(posedge hclk);
        chkd(1'b0);
        wait_diag(1'b1, 30);
        chkw(`ERR_WATCHDOG);
        $display("test watchdog done");
        test_done;
    end
endmodule

`default_nettype wire
